// *** design/ubde_engine.sv ***
/*
 * Buffer descriptor engine: fetches a descriptor per token, decides the
 * handshake, steers packet bytes to and from memory and writes the
 * descriptor back. Assumes the serial engine (same clock) presents one
 * token at a time and pushes or pulls bytes with valid/ready, and that
 * memory answers every request with MEM_ACK (read data valid with it).
 */
// Function
// - each descriptor is 8 bytes, four per endpoint from zero upward
// - table base gives upper 23 address bits; table 512-byte aligned
// - descriptor address is base, endpoint, direction, parity, offset
// - direction bit is 1 for transmit and 0 for receive
// - per endpoint and direction parity picks odd/even, flips on done
// - ownership bit hands descriptor to engine; cleared on completion
// - ten-bit byte count in bits 25-16, range 0 to 1023
// - completion rewrites byte count with bytes actually moved
// - receive longer than count flags overflow and drops the excess
// - control bit 6 picks DATA1/DATA0 or the expected receive PID
// - reception writes received toggle into bit 6; transmit keeps it
// - keep bit holds descriptor owned, no status push, no done flag
// - address hold bit freezes the buffer address during transfer
// - toggle mismatch with checking on is NAKed, buffer untouched
// - buffer stall answers STALL, sets stall flags, descriptor intact
// - SETUP token to a stalled buffer clears its stall bit
// - function mode writes token PID: OUT 1, IN 9, SETUP D
// - host mode writes the returned PID or status code
// - second word is the buffer start address used for data
// - descriptor valid only when its endpoint is enabled
// - host mode runs only endpoint zero transactions; other endpoints get NAK
// - unowned descriptor gets NAK and is left untouched
// - completion pushes endpoint and direction, raises done flag
`timescale 1ns/1ps
module ubde_engine (
   input  wire logic               CLK,
   input  wire logic               SYS_RST,
   input  wire logic [22:0]        TABLE_BASE,
   input  wire logic [15:0]        ENDPOINT_ENABLE,
   input  wire logic               HOST_MODE,
   input  wire logic               TOK_VALID,
   input  wire ubde_pkg::ubde_tok_t TOK,
   output logic                    TOK_READY,
   output logic                    HS_VALID,
   output ubde_pkg::ubde_hs_t      HS,
   output logic                    TX_DATA1,
   input  wire logic               RX_VALID,
   input  wire logic [7:0]         RX_BYTE,
   output logic                    RX_READY,
   output logic                    TX_VALID,
   output logic [7:0]              TX_BYTE,
   input  wire logic               TX_READY,
   input  wire logic               END_VALID,
   input  wire ubde_pkg::ubde_end_t END_INFO,
   output logic                    MEM_REQ,
   output ubde_pkg::ubde_mreq_t    MEM,
   input  wire logic               MEM_ACK,
   input  wire logic [31:0]        MEM_RDATA,
   output logic                    TRANSFER_DONE_FLAG,
   output ubde_pkg::ubde_stat_t    TRANSFER_STATUS_QUEUE,
   output logic                    STALL_EVENT_FLAG,
   output logic [15:0]             ENDPOINT_STALLED_FLAG,
   output logic                    OVERFLOW_FLAG
);
   typedef enum logic [3:0] {
      S_IDLE, S_RDC, S_RDA, S_DEC, S_XFER, S_RDB, S_WRB, S_WAIT, S_WBK,
      S_DONE
   } ubde_st_t;

   ubde_st_t            st_q;
   ubde_pkg::ubde_tok_t tok_q;
   logic [31:0]         ctl_q;
   logic [31:0]         badr_q;
   logic [9:0]          cnt_q;
   logic [10:0]         len_q;
   logic [31:0]         word_q;
   logic [1:0]          lane_q;
   logic                wpend_q;
   logic                end_seen_q;
   logic [31:0]         pp_q;
   logic                ovf_q;
   logic [3:0]          rpid_q;
   logic                rtgl_q;
   logic [31:0]         desc_adr;
   logic                pp_sel;
   logic                owned, stall_b, tgl_bad, tx_dir;
   logic [31:0]         wb_word;

   // two-entry skid buffer between serial engine receive and packing
   logic [7:0] rb_d0_q, rb_d1_q;
   logic [1:0] rb_n_q;
   logic       rb_pop, rb_push;

   assign tx_dir  = tok_q.tx;
   assign pp_sel  = pp_q[{tok_q.ep, tok_q.tx}];
   assign desc_adr = {TABLE_BASE, tok_q.ep, tok_q.tx, pp_sel,
                      3'h0};
   assign owned   = ctl_q[ubde_pkg::OWN_BIT]
                    && ENDPOINT_ENABLE[tok_q.ep]
                    && !(HOST_MODE && tok_q.ep != 4'h0);
   assign stall_b = ctl_q[ubde_pkg::STL_BIT];
   assign tgl_bad = !tx_dir && ctl_q[ubde_pkg::CHK_BIT]
                    && END_INFO.data1 != ctl_q[ubde_pkg::TGL_BIT];

   always_comb begin
      wb_word = ctl_q;
      wb_word[25:16] = len_q[9:0];
      wb_word[ubde_pkg::OWN_BIT] = ctl_q[ubde_pkg::KEEP_BIT];
      if (!tx_dir) begin
         wb_word[ubde_pkg::TGL_BIT] = rtgl_q;
      end
      wb_word[5:2] = HOST_MODE ? rpid_q : tok_q.pid;
   end

   assign rb_push = RX_VALID && RX_READY;
   assign rb_pop  = st_q == S_XFER && !tx_dir && rb_n_q != 2'h0 && !wpend_q;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rb_n_q  <= 2'h0;
         rb_d0_q <= 8'h00;
         rb_d1_q <= 8'h00;
      end else begin
         if (rb_pop) begin
            rb_d0_q <= rb_d1_q;
         end
         if (rb_push) begin
            if (rb_n_q == 2'h0 || (rb_n_q == 2'h1 && rb_pop)) begin
               rb_d0_q <= RX_BYTE;
            end else begin
               rb_d1_q <= RX_BYTE;
            end
         end
         rb_n_q <= rb_n_q + {1'b0, rb_push} - {1'b0, rb_pop};
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RX_READY <= 1'b0;
      end else begin
         // back-pressure reaches the serial engine one cycle early
         RX_READY <= st_q == S_XFER && !tx_dir
                     && (rb_n_q == 2'h0 || (rb_n_q == 2'h1 && !rb_push));
      end
   end

   // main sequencer
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_q      <= S_IDLE;
         tok_q     <= '0;
         ctl_q     <= 32'h0000_0000;
         badr_q    <= 32'h0000_0000;
         cnt_q     <= 10'h000;
         len_q     <= 11'h000;
         word_q    <= 32'h0000_0000;
         lane_q    <= 2'h0;
         wpend_q   <= 1'b0;
         end_seen_q <= 1'b0;
         ovf_q     <= 1'b0;
         rpid_q    <= 4'h0;
         rtgl_q    <= 1'b0;
         TOK_READY <= 1'b0;
         HS_VALID  <= 1'b0;
         HS        <= ubde_pkg::UBDE_HS_NAK;
         TX_DATA1  <= 1'b0;
         TX_VALID  <= 1'b0;
         TX_BYTE   <= 8'h00;
         MEM_REQ   <= 1'b0;
         MEM       <= '0;
      end else begin
         HS_VALID  <= 1'b0;
         TOK_READY <= 1'b0;
         // end pulse may come while a byte store is still pending
         end_seen_q <= end_seen_q || END_VALID;
         unique case (st_q)
            S_IDLE: begin
               if (TOK_VALID && !TOK_READY) begin
                  tok_q     <= TOK;
                  TOK_READY <= 1'b1;
                  st_q      <= S_RDC;
               end
            end
            S_RDC: begin
               MEM_REQ <= !MEM_ACK;
               MEM     <= '{wr: 1'b0, addr: desc_adr | 32'(ubde_pkg::OFS_CTRL),
                            wdata: 32'h0000_0000};
               if (MEM_ACK && MEM_REQ) begin
                  ctl_q <= MEM_RDATA;
                  st_q  <= S_RDA;
               end
            end
            S_RDA: begin
               MEM_REQ <= !MEM_ACK;
               MEM.addr <= desc_adr | 32'(ubde_pkg::OFS_ADDR);
               if (MEM_ACK && MEM_REQ) begin
                  badr_q <= MEM_RDATA;
                  st_q   <= S_DEC;
               end
            end
            S_DEC: begin
               cnt_q   <= ctl_q[25:16];
               len_q   <= 11'h000;
               lane_q  <= 2'h0;
               word_q  <= 32'h0000_0000;
               ovf_q   <= 1'b0;
               end_seen_q <= 1'b0;
               TX_DATA1 <= ctl_q[ubde_pkg::TGL_BIT];
               if (!owned) begin
                  HS_VALID <= 1'b1;
                  HS       <= ubde_pkg::UBDE_HS_NAK;
                  st_q     <= S_IDLE;
               end else if (stall_b) begin
                  HS_VALID <= 1'b1;
                  HS       <= ubde_pkg::UBDE_HS_STALL;
                  st_q     <= tok_q.pid == ubde_pkg::PID_SETUP ? S_WBK
                                                              : S_IDLE;
               end else begin
                  st_q <= tx_dir ? S_RDB : S_XFER;
               end
            end
            S_RDB: begin
               MEM_REQ  <= !MEM_ACK;
               MEM.wr   <= 1'b0;
               MEM.addr <= {badr_q[31:2], 2'h0};
               if (MEM_ACK && MEM_REQ) begin
                  word_q <= MEM_RDATA;
                  st_q   <= S_XFER;
               end
            end
            S_XFER: begin
               if (tx_dir) begin
                  if (len_q[9:0] == cnt_q) begin
                     TX_VALID <= 1'b0;
                     st_q     <= S_WAIT;
                  end else if (!TX_VALID || TX_READY) begin
                     TX_VALID <= !TX_VALID;
                     TX_BYTE  <= word_q[8*badr_q[1:0] +: 8];
                     if (TX_VALID) begin
                        len_q <= len_q + 11'h001;
                        if (!ctl_q[ubde_pkg::HOLD_BIT]) begin
                           badr_q <= badr_q + 32'h0000_0001;
                           if (badr_q[1:0] == 2'h3) begin
                              st_q <= S_RDB;
                           end
                        end
                     end
                  end
               end else if (wpend_q) begin
                  st_q <= S_WRB;
               end else if (rb_pop) begin
                  if (len_q[9:0] < cnt_q && !len_q[10]
                      && !tgl_bad) begin
                     word_q[8*badr_q[1:0] +: 8] <= rb_d0_q;
                     lane_q <= badr_q[1:0];
                     wpend_q <= 1'b1;
                     len_q  <= len_q + 11'h001;
                  end else if (!tgl_bad) begin
                     ovf_q <= 1'b1;
                  end
               end else if ((END_VALID || end_seen_q) && rb_n_q == 2'h0) begin
                  st_q <= S_WAIT;
               end
            end
            S_WRB: begin
               // byte write via read-modify-free single lane store
               MEM_REQ <= !MEM_ACK;
               MEM     <= '{wr: 1'b1, addr: badr_q,
                            wdata: word_q};
               if (MEM_ACK && MEM_REQ) begin
                  wpend_q <= 1'b0;
                  if (!ctl_q[ubde_pkg::HOLD_BIT]) begin
                     badr_q <= badr_q + 32'h0000_0001;
                  end
                  st_q <= S_XFER;
               end
            end
            S_WAIT: begin
               if (END_VALID || end_seen_q) begin
                  rtgl_q <= END_INFO.data1;
                  rpid_q <= END_INFO.host_pid;
                  HS_VALID <= !HOST_MODE;
                  if (END_INFO.fail || tgl_bad) begin
                     HS   <= ubde_pkg::UBDE_HS_NAK;
                     st_q <= S_IDLE;
                  end else begin
                     HS   <= ubde_pkg::UBDE_HS_ACK;
                     st_q <= S_WBK;
                  end
               end
            end
            S_WBK: begin
               MEM_REQ <= !MEM_ACK;
               MEM.wr  <= 1'b1;
               MEM.addr <= desc_adr;
               MEM.wdata <= stall_b
                  ? (ctl_q & ~(32'h1 << ubde_pkg::STL_BIT))
                  : wb_word;
               if (MEM_ACK && MEM_REQ) begin
                  st_q <= stall_b ? S_IDLE : S_DONE;
               end
            end
            S_DONE: begin
               st_q <= S_IDLE;
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   // parity flips on every completed descriptor without the keep bit
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pp_q <= 32'h0000_0000;
      end else if (st_q == S_DONE && !ctl_q[ubde_pkg::KEEP_BIT]) begin
         pp_q[{tok_q.ep, tok_q.tx}] <= !pp_sel;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         TRANSFER_DONE_FLAG    <= 1'b0;
         TRANSFER_STATUS_QUEUE <= '0;
         STALL_EVENT_FLAG      <= 1'b0;
         ENDPOINT_STALLED_FLAG <= 16'h0000;
         OVERFLOW_FLAG         <= 1'b0;
      end else begin
         TRANSFER_DONE_FLAG <= st_q == S_DONE
                               && !ctl_q[ubde_pkg::KEEP_BIT];
         if (st_q == S_DONE && !ctl_q[ubde_pkg::KEEP_BIT]) begin
            TRANSFER_STATUS_QUEUE <= '{ep: tok_q.ep, tx: tok_q.tx,
                                       odd: pp_sel};
         end
         STALL_EVENT_FLAG <= st_q == S_DEC && owned && stall_b;
         if (st_q == S_DEC && owned && stall_b) begin
            ENDPOINT_STALLED_FLAG[tok_q.ep] <= 1'b1;
         end
         if (st_q == S_DEC) begin
            OVERFLOW_FLAG <= 1'b0;
         end else if (ovf_q) begin
            OVERFLOW_FLAG <= 1'b1;
         end
      end
   end

   property p_wbk_own;
      @(posedge CLK) disable iff (SYS_RST)
      MEM_REQ && MEM.wr && st_q == S_WBK && !stall_b
      && !ctl_q[ubde_pkg::KEEP_BIT] |-> !MEM.wdata[ubde_pkg::OWN_BIT];
   endproperty
   a_wbk_own: assert property (p_wbk_own)
      else $error("ownership not returned on write-back");
   a_nak_unowned: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_q == S_DEC && !owned |=> HS_VALID && HS == ubde_pkg::UBDE_HS_NAK)
      else $error("unowned descriptor not NAKed");
   a_done_keep: assert property (@(posedge CLK) disable iff (SYS_RST)
      TRANSFER_DONE_FLAG |-> !ctl_q[ubde_pkg::KEEP_BIT])
      else $error("done flag raised in keep mode");
   a_addr_fmt: assert property (@(posedge CLK) disable iff (SYS_RST)
      MEM_REQ && st_q == S_RDC |-> MEM.addr[31:9] == TABLE_BASE)
      else $error("descriptor address base wrong");
   a_stall_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(STALL_EVENT_FLAG) |-> HS == ubde_pkg::UBDE_HS_STALL)
      else $error("stall event without stall handshake");
   a_no_overrun: assert property (@(posedge CLK) disable iff (SYS_RST)
      len_q[9:0] <= cnt_q || st_q == S_DEC || st_q == S_IDLE)
      else $error("stored more bytes than the count");
   c_done: cover property (@(posedge CLK) TRANSFER_DONE_FLAG);
   c_stall: cover property (@(posedge CLK) STALL_EVENT_FLAG);
   c_ovf: cover property (@(posedge CLK) OVERFLOW_FLAG);
endmodule : ubde_engine

// *** design/ubde_pkg.sv ***
/*
 * Package for the buffer descriptor engine: descriptor layout, address
 * fields, PID codes and the packed structs carried between ports.
 * Assumes a 32-bit system memory reached one word per request.
 */
package ubde_pkg;
   localparam int DESC_BYTES      = 8;
   localparam int BASE_LSB        = 9;
   localparam int EP_LSB          = 5;
   localparam int DIR_BIT         = 4;
   localparam int PP_BIT          = 3;
   localparam logic [2:0] OFS_CTRL = 3'h0;
   localparam logic [2:0] OFS_ADDR = 3'h4;
   localparam int OWN_BIT         = 7;
   localparam int TGL_BIT         = 6;
   localparam int KEEP_BIT        = 5;
   localparam int HOLD_BIT        = 4;
   localparam int CHK_BIT         = 3;
   localparam int STL_BIT         = 2;
   localparam int PID_LSB         = 2;
   localparam int CNT_LSB         = 16;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   localparam logic [3:0] PID_OUT   = 4'h1;
   localparam logic [3:0] PID_IN    = 4'h9;
   localparam logic [3:0] PID_SETUP = 4'hD;
   localparam logic [3:0] PID_DATA0 = 4'h3;
   localparam logic [3:0] PID_DATA1 = 4'hB;
   localparam logic [3:0] PID_ACK   = 4'h2;
   localparam logic [3:0] PID_STALL = 4'hE;
   localparam logic [3:0] PID_NAK   = 4'hA;
   localparam logic [3:0] PID_TMO   = 4'h0;
   localparam logic [3:0] PID_ERR   = 4'hF;

   typedef enum logic [1:0] {
      UBDE_HS_ACK, UBDE_HS_NAK, UBDE_HS_STALL
   } ubde_hs_t;

   // token from the serial engine
   typedef struct packed {
      logic [3:0] ep;
      logic       tx;
      logic [3:0] pid;
   } ubde_tok_t;

   // end of a data phase reported by the serial engine
   typedef struct packed {
      logic [10:0] len;
      logic        data1;
      logic        fail;
      logic [3:0]  host_pid;
   } ubde_end_t;

   // memory request
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ubde_mreq_t;

   // completion entry for the transfer status queue
   typedef struct packed {
      logic [3:0] ep;
      logic       tx;
      logic       odd;
   } ubde_stat_t;
endpackage : ubde_pkg

// *** tb/ubde_mem_model.sv ***
/*
 * Memory partner for the descriptor engine bench: word memory that
 * answers each request after a short or a long wait, plus a byte log.
 * Assumes requests hold until acknowledged, byte lane from addr[1:0].
 */
`timescale 1ns/1ps
module ubde_mem_model (
   input  wire logic                 CLK,
   input  wire logic                 SYS_RST,
   input  wire logic                 SLOW,
   input  wire logic                 MEM_REQ,
   input  wire ubde_pkg::ubde_mreq_t MEM,
   output logic                      MEM_ACK,
   output logic [31:0]               MEM_RDATA
);
   logic [31:0] mem  [0:1023];
   logic [7:0]  bmem [0:4095];
   logic [2:0]  wait_q;

   // a reset leaves descriptors and buffers as they were
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         MEM_ACK   <= 1'b0;
         wait_q    <= 3'h0;
         MEM_RDATA <= 32'h5AA5_C33C;
      end else if (MEM_ACK || !MEM_REQ) begin
         MEM_ACK   <= 1'b0;
         wait_q    <= 3'h0;
         // no stale data between answers
         MEM_RDATA <= ~MEM_RDATA;
      end else if (wait_q < (SLOW ? 3'h4 : 3'h0)) begin
         wait_q <= wait_q + 3'h1;
      end else begin
         MEM_ACK <= 1'b1;
         if (MEM.wr) begin
            mem[MEM.addr[11:2]]  <= MEM.wdata;
            bmem[MEM.addr[11:0]] <= MEM.wdata[8 * MEM.addr[1:0] +: 8];
         end else begin
            MEM_RDATA <= mem[MEM.addr[11:2]];
         end
      end
   end
endmodule : ubde_mem_model

// *** tb/usb_buffer_descriptor_engine_bench.sv ***
/*
 * Self-checking bench for the descriptor engine: plays the serial
 * engine, keeps descriptors in the memory partner, scores handshakes,
 * sent bytes and status pushes. Assumes package and partner compiled.
 */
`timescale 1ns/1ps
module usb_buffer_descriptor_engine_bench;
   logic                 CLK, SYS_RST, HOST_MODE, TOK_VALID, SLOW;
   logic                 RX_VALID, TX_READY, END_VALID, TOK_READY;
   logic                 HS_VALID, TX_DATA1, RX_READY, TX_VALID;
   logic                 MEM_REQ, MEM_ACK, TRANSFER_DONE_FLAG;
   logic                 STALL_EVENT_FLAG, OVERFLOW_FLAG;
   logic [22:0]          TABLE_BASE;
   logic [15:0]          ENDPOINT_ENABLE, ENDPOINT_STALLED_FLAG;
   logic [7:0]           RX_BYTE, TX_BYTE;
   logic [31:0]          MEM_RDATA, rnd, pp;
   ubde_pkg::ubde_tok_t  TOK;
   ubde_pkg::ubde_end_t  END_INFO;
   ubde_pkg::ubde_hs_t   HS;
   ubde_pkg::ubde_mreq_t MEM;
   ubde_pkg::ubde_stat_t TRANSFER_STATUS_QUEUE;
   logic [31:0]          hs_q[$], tx_q[$], st_q[$];
   logic [7:0]           bb[0:15];
   int                   errors, checks, cyc, stall_n, tn;
   localparam int        ACK = int'(ubde_pkg::UBDE_HS_ACK);
   localparam int        NAK = int'(ubde_pkg::UBDE_HS_NAK);
   localparam int        STL = int'(ubde_pkg::UBDE_HS_STALL);

   ubde_engine i_ubde_engine (.CLK(CLK), .SYS_RST(SYS_RST),
      .TABLE_BASE(TABLE_BASE), .ENDPOINT_ENABLE(ENDPOINT_ENABLE),
      .HOST_MODE(HOST_MODE), .TOK_VALID(TOK_VALID), .TOK(TOK),
      .TOK_READY(TOK_READY), .HS_VALID(HS_VALID), .HS(HS),
      .TX_DATA1(TX_DATA1), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
      .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
      .TX_READY(TX_READY), .END_VALID(END_VALID), .END_INFO(END_INFO),
      .MEM_REQ(MEM_REQ), .MEM(MEM), .MEM_ACK(MEM_ACK),
      .MEM_RDATA(MEM_RDATA), .TRANSFER_DONE_FLAG(TRANSFER_DONE_FLAG),
      .TRANSFER_STATUS_QUEUE(TRANSFER_STATUS_QUEUE),
      .STALL_EVENT_FLAG(STALL_EVENT_FLAG),
      .ENDPOINT_STALLED_FLAG(ENDPOINT_STALLED_FLAG),
      .OVERFLOW_FLAG(OVERFLOW_FLAG));
   ubde_mem_model i_ubde_mem_model (.CLK(CLK), .SYS_RST(SYS_RST),
      .SLOW(SLOW), .MEM_REQ(MEM_REQ), .MEM(MEM), .MEM_ACK(MEM_ACK),
      .MEM_RDATA(MEM_RDATA));

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? (x >> 1) ^ 32'hA300_0000 : x >> 1;
   endfunction : lfsr

   // f holds bits 6:2 of the control word
   function automatic logic [31:0] ctl(input logic o, input logic [9:0] n,
      input logic [4:0] f);
      return {6'h00, n, 8'h00, o, f, 2'h0};
   endfunction : ctl

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic hold_until(ref logic s);
      int t;
      t = 0;
      do begin
         @(posedge CLK);
         t++;
      end while (s !== 1'b1 && t < 50);
      #1;
   endtask : hold_until

   // ec all ones skips the descriptor compare, ns < 0 the buffer one
   task automatic run(input logic [3:0] ep, input logic tx,
      input logic [3:0] pid, input logic [31:0] c, input int n,
      input logic d1, input logic [3:0] hp, input int hs,
      input logic done, input logic [31:0] ec, input int ns);
      logic [31:0] da, ba;
      logic [11:0] a;
      int          k, t, q;
      da = {TABLE_BASE, ep, tx, pp[{ep, tx}], 3'h0};
      ba = 32'h0000_0401 + 32'(ep) * 128 + 32'(tx) * 64;
      for (k = 0; k < 16; k++) begin
         rnd = lfsr(rnd);
         bb[k] = rnd[7:0];
         a = ba[11:0] + 12'(k);
         i_ubde_mem_model.bmem[a] = 8'hEE;
         if (tx && k < n) begin
            i_ubde_mem_model.mem[a[11:2]][8 * a[1:0] +: 8] = bb[k];
            tx_q.push_back(32'(bb[k]));
         end
      end
      i_ubde_mem_model.mem[da[11:2] + 10'h1] = ba;
      i_ubde_mem_model.mem[da[11:2]] = c;
      SLOW = rnd[9];
      if (hs >= 0) hs_q.push_back(32'(hs));
      if (done) begin
         st_q.push_back(32'({ep, tx, pp[{ep, tx}]}));
         pp[{ep, tx}] = ~pp[{ep, tx}];
      end
      TOK_VALID = 1'b1;
      TOK = '{ep: ep, tx: tx, pid: pid};
      END_INFO = '{len: 11'(n), data1: d1, fail: 1'b0, host_pid: hp};
      hold_until(TOK_READY);
      TOK_VALID = 1'b0;
      for (k = 0; k < n && !tx; k++) begin
         RX_VALID = 1'b1;
         RX_BYTE = bb[k];
         hold_until(RX_READY);
      end
      RX_VALID = 1'b0;
      for (t = 0; tx_q.size() > 0 && t < 400; t++) begin
         @(posedge CLK);
         #1;
      end
      if (!(tx && n == 0)) begin
         END_VALID = 1'b1;
         @(posedge CLK);
         #1;
         END_VALID = 1'b0;
      end
      // settled once memory and both queues stay quiet for a while
      q = 0;
      for (t = 0; q < 8 && t < 500; t++) begin
         @(posedge CLK);
         #1;
         q = (MEM_REQ || hs_q.size() > 0 || st_q.size() > 0) ? 0 : q + 1;
      end
      check(32'(hs_q.size() + st_q.size() + tx_q.size()), 32'h0);
      hs_q.delete();
      st_q.delete();
      tx_q.delete();
      if (ec !== 32'hFFFF_FFFF) begin
         check(i_ubde_mem_model.mem[da[11:2]], ec);
      end
      for (k = 0; k < ns; k++) begin
         check(i_ubde_mem_model.bmem[ba[11:0] + 12'(k)], bb[k]);
      end
      if (ns >= 0) begin
         check(i_ubde_mem_model.bmem[ba[11:0] + 12'(ns)], 8'hEE);
      end
      $display("test %0d ended", tn++);
   endtask : run

   always @(posedge CLK) begin
      cyc++;
      if (!SYS_RST && HS_VALID === 1'b1 && hs_q.size() > 0) begin
         check(32'(HS), hs_q.pop_front());
      end
      if (!SYS_RST && TX_VALID === 1'b1 && TX_READY) begin
         check(32'(TX_BYTE), tx_q.size() > 0 ? tx_q.pop_front() : '1);
      end
      if (!SYS_RST && TRANSFER_DONE_FLAG !== 1'b0) begin
         check(32'(TRANSFER_STATUS_QUEUE),
               st_q.size() > 0 ? st_q.pop_front() : '1);
      end
      if (!SYS_RST && STALL_EVENT_FLAG === 1'b1) stall_n++;
      if (cyc == 30000) begin
         errors++;
         wrap_up();
      end
   end

   // receiver stalls at random
   always @(posedge CLK) begin
      #1;
      TX_READY = rnd[3] | rnd[6];
      rnd = lfsr(rnd);
   end

   initial begin
      SYS_RST = 1'b1;
      {HOST_MODE, TOK_VALID, SLOW, RX_VALID, TX_READY, END_VALID} = '0;
      TABLE_BASE = 23'h000001;
      ENDPOINT_ENABLE = 16'h007F;
      RX_BYTE = 8'h00;
      TOK = '0;
      END_INFO = '0;
      rnd = 32'hAF1E;
      pp = '0;
      for (int i = 0; i < 1024; i++) i_ubde_mem_model.mem[i] = 32'h0;
      repeat (3) @(posedge CLK);
      #1;
      SYS_RST = 1'b0;
      run(1, 0, 4'h1, ctl(1, 4, 5'h00), 4, 0, 0, ACK, 1, ctl(0, 4, 5'h01), 4);
      run(1, 0, 4'h1, ctl(1, 3, 5'h12), 6, 1, 0, ACK, 1, '1, 3);
      check(OVERFLOW_FLAG, 1);
      run(1, 0, 4'h1, ctl(1, 4, 5'h12), 4, 0, 0, NAK, 0, ctl(1, 4, 5'h12), 0);
      run(2, 1, 4'h9, ctl(0, 2, 5'h00), 0, 0, 0, NAK, 0, ctl(0, 2, 5'h00), -1);
      run(7, 1, 4'h9, ctl(1, 2, 5'h00), 0, 0, 0, NAK, 0, ctl(1, 2, 5'h00), -1);
      run(3, 0, 4'h1, ctl(1, 4, 5'h01), 0, 0, 0, STL, 0, ctl(1, 4, 5'h01), 0);
      check(32'(stall_n), 1);
      check(ENDPOINT_STALLED_FLAG, 16'h0008);
      run(3, 0, 4'hD, ctl(1, 4, 5'h01), 0, 0, 0, STL, 0, ctl(1, 4, 5'h00), 0);
      check(32'(stall_n), 2);
      run(4, 1, 4'h9, ctl(1, 5, 5'h10), 5, 0, 0, -1, 1, ctl(0, 5, 5'h19), -1);
      check(TX_DATA1, 1);
      run(5, 0, 4'h1, ctl(1, 2, 5'h08), 2, 0, 0, ACK, 0, '1, -1);
      check(i_ubde_mem_model.mem[10'h0A8][7], 1);
      run(6, 0, 4'h1, ctl(1, 3, 5'h04), 3, 0, 0, ACK, 1, ctl(0, 3, 5'h01), -1);
      check(i_ubde_mem_model.bmem[12'h701], bb[2]);
      check(i_ubde_mem_model.bmem[12'h702], 8'hEE);
      HOST_MODE = 1'b1;
      run(0, 0, 4'h9, ctl(1, 2, 5'h00), 2, 1, 4'hB, -1, 1, ctl(0, 2, 5'h1B), 2);
      wrap_up();
   end
endmodule : usb_buffer_descriptor_engine_bench
